/* cpu_exec_params.svh */
// Constants for the break, call, clear and compare execution block.
// Assumes a 16-bit instruction word and an 8-bit data path.
// How it works
// - Plain break flushes, stops execution, idles on nops; one cycle, no flags.
// - Halted core resumes only on reset or a debug port command.
// - Skip-extending break halts like plain break, takes two cycles, then skips.
// - Call pushes the full 16-bit address of the next instruction.
// - Call loads PC 12:0 from instruction, 15:13 from page bits; three cycles.
// - Clear writes zero to the operand location and sets zero flag; one cycle.
// - Bit clear clears one selected bit only and alters no flags.
// - Register compare subtracts accumulator from operand, updates only flags.
// - Literal compare subtracts accumulator from immediate, updates only flags.
// - Compare clears carry on negative difference, sets it otherwise.
// - Compare clears nibble carry on borrow from bit 3, sets it otherwise.
// - Compare sets zero flag on zero difference, clears it otherwise.
// - Register skip-if-equal skips next instruction when operand equals accumulator.
// - Literal skip-if-equal skips next instruction when immediate equals accumulator.
// - Register skip-if-unequal skips next instruction when they differ.
// - Literal skip-if-unequal skips next instruction when they differ.
// - Compare-and-skip takes one cycle, or two when the skip is taken.
// - Compare-and-skip leaves carry, nibble carry and zero flags untouched.
`ifndef CPU_EXEC_PARAMS_SVH
`define CPU_EXEC_PARAMS_SVH

// ==========================================================
// Register offsets (byte addresses)
`define REG_STATUS      8'h00
`define REG_ACC         8'h04
`define REG_PC          8'h08
`define REG_STACK_TOP   8'h0C
`define REG_FILE_ADDR   8'h10
`define REG_FILE_DATA   8'h14

// ==========================================================
// Status field positions
`define FLD_CARRY       0
`define FLD_NIBBLE      1
`define FLD_ZERO        2
`define FLD_PAGE_LO     3
`define FLD_PAGE_HI     5
`define FLD_HALTED      8

// ==========================================================
// Reset values
`define RST_PC          16'h0000
`define RST_ACC         8'h00
`define RST_FLAGS       3'h0
`define RST_PAGE        3'h0

// ==========================================================
// Opcodes and opcode fields
`define OPC_BREAK       16'h0001
`define OPC_BREAKX      16'h0005
`define OPC_CALL        3'h6
`define OPC_CLR         7'h03
`define OPC_CMP         7'h02
`define OPC_CSE         7'h21
`define OPC_CSNE        7'h20
`define OPC_CLRB        4'h8
`define OPC_CMPL        8'h79
`define OPC_CSEL        8'h77
`define OPC_CSNEL       8'h76

// ==========================================================
// Timing and sizes
`define STACK_DEPTH     16
`define FILE_WORDS      512

`endif

/* cpu_exec_pkg.sv */
// Types shared by the execution block.
// Assumes cpu_exec_params.svh supplies the numeric constants.
package cpu_exec_pkg;

    typedef enum logic [2:0] {
        st_run,
        st_skip,
        st_brkx,
        st_call2,
        st_call3,
        st_halt
    } exec_state_type;

endpackage

/* cmp_if.sv */
// Operand bundle between the core and its compare unit.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface cmp_if;
    logic [7:0] operand;
    logic [7:0] acc;
    logic       carry;
    logic       nibble_carry;
    logic       zero;
    logic       equal;

    modport core (output operand, output acc, input carry, input nibble_carry,
                  input zero, input equal);
    modport unit (input operand, input acc, output carry, output nibble_carry,
                  output zero, output equal);
endinterface

/* cmp_unit.sv */
// Subtract-compare flag generator: operand minus accumulator.
// Assumes purely combinational use inside one clock domain.
`timescale 1ns/1ps
module cmp_unit (
    cmp_if.unit c
);
    wire [7:0] diff;

    assign diff           = c.operand - c.acc;
    assign c.carry        = (c.operand >= c.acc);
    assign c.nibble_carry = (c.operand[3:0] >= c.acc[3:0]);
    assign c.zero         = (diff == 8'h00);
    assign c.equal        = (c.operand == c.acc);
endmodule

/* ret_stack.sv */
// Hardware return stack, push side only.
// Assumes the caller pushes at most once per cycle; overflow wraps.
`timescale 1ns/1ps
`include "cpu_exec_params.svh"
module ret_stack (
    input  wire logic        ref_clk_i,
    input  wire logic        nrst_i,
    input  wire logic        push_i,
    input  wire logic [15:0] push_data_i,
    output logic      [15:0] top_o
);
    logic [15:0] mem_q [`STACK_DEPTH];
    logic [3:0]  ptr_q;

    // Oldest entry is overwritten on overflow, as a real call chain would lose it
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ptr_q <= 4'h0;
        end else if (push_i) begin
            ptr_q <= ptr_q + 4'h1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (push_i) begin
            mem_q[ptr_q] <= push_data_i;
        end
    end

    assign top_o = mem_q[ptr_q - 4'h1];
endmodule

/* cpu_break_call_compare_ops.sv */
// Execution core for break, call, clear, bit clear, compare and compare-skip.
// Assumes program memory answers instr_i combinationally for pc_o in the
// same clock domain; debug commands arrive asynchronously on a pin.
`timescale 1ns/1ps
`include "cpu_exec_params.svh"
module cpu_break_call_compare_ops (
    input  wire logic        ref_clk_i,
    input  wire logic        nrst_i,
    output logic      [15:0] pc_o,
    input  wire logic [15:0] instr_i,
    input  wire logic        debug_resume_i,
    output logic             halted_o,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o
);
    // ==========================================================
    // State
    cpu_exec_pkg::exec_state_type state_q, state_d;
    logic [15:0] pc_q, pc_d;
    logic [7:0]  acc_q;
    logic [2:0]  page_q;
    logic        carry_q, nibble_q, zero_q;
    logic        resume_skip_q;
    logic [7:0]  file_q [`FILE_WORDS];
    logic [8:0]  file_addr_q;
    logic        dbg_meta_q, dbg_sync_q, dbg_prev_q;
    logic [31:0] prdata_q;
    logic        slverr_q;
    logic [15:0] stack_top;

    // ==========================================================
    // Debug command pin synchroniser
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            dbg_meta_q <= 1'b0;
            dbg_sync_q <= 1'b0;
            dbg_prev_q <= 1'b0;
        end else begin
            dbg_meta_q <= debug_resume_i;
            dbg_sync_q <= dbg_meta_q;
            dbg_prev_q <= dbg_sync_q;
        end
    end

    wire resume_evt = dbg_sync_q & ~dbg_prev_q;

    // ==========================================================
    // Decode
    wire       running    = (state_q == cpu_exec_pkg::st_run);
    wire [8:0] f_addr     = instr_i[8:0];
    wire [2:0] bit_sel    = instr_i[11:9];
    wire [7:0] imm_byte   = instr_i[7:0];
    wire [7:0] file_operand = file_q[f_addr];

    wire is_break  = running & (instr_i == `OPC_BREAK);
    wire is_breakx = running & (instr_i == `OPC_BREAKX);
    wire is_call   = running & (instr_i[15:13] == `OPC_CALL);
    wire is_clr    = running & (instr_i[15:9] == `OPC_CLR);
    wire is_clrb   = running & (instr_i[15:12] == `OPC_CLRB);
    wire is_cmp    = running & (instr_i[15:9] == `OPC_CMP);
    wire is_cmpl   = running & (instr_i[15:8] == `OPC_CMPL);
    wire is_cse    = running & (instr_i[15:9] == `OPC_CSE);
    wire is_csne   = running & (instr_i[15:9] == `OPC_CSNE);
    wire is_csel   = running & (instr_i[15:8] == `OPC_CSEL);
    wire is_csnel  = running & (instr_i[15:8] == `OPC_CSNEL);
    wire use_imm   = is_cmpl | is_csel | is_csnel;

    // ==========================================================
    // Compare unit
    cmp_if cmp_bus ();

    assign cmp_bus.operand = use_imm ? imm_byte : file_operand;
    assign cmp_bus.acc     = acc_q;

    cmp_unit i_cmp_unit (
        .c (cmp_bus.unit)
    );

    wire is_skip_op = is_cse | is_csne | is_csel | is_csnel;
    wire skip_taken = ((is_cse | is_csel) & cmp_bus.equal)
                    | ((is_csne | is_csnel) & ~cmp_bus.equal);
    wire flags_wr   = is_cmp | is_cmpl;
    wire [15:0] pc_next = pc_q + 16'h0001;

    // ==========================================================
    // Return stack
    ret_stack i_ret_stack (
        .ref_clk_i   (ref_clk_i),
        .nrst_i      (nrst_i),
        .push_i      (is_call),
        .push_data_i (pc_next),
        .top_o       (stack_top)
    );

    // ==========================================================
    // Sequencer
    always_comb begin
        state_d = state_q;
        pc_d    = pc_q;
        unique case (state_q)
            cpu_exec_pkg::st_run: begin
                pc_d = pc_next;
                if (is_break) begin
                    state_d = cpu_exec_pkg::st_halt;
                end else if (is_breakx) begin
                    state_d = cpu_exec_pkg::st_brkx;
                end else if (is_call) begin
                    pc_d    = {page_q, instr_i[12:0]};
                    state_d = cpu_exec_pkg::st_call2;
                end else if (skip_taken) begin
                    state_d = cpu_exec_pkg::st_skip;
                end
            end
            cpu_exec_pkg::st_skip: begin
                pc_d    = pc_next;
                state_d = cpu_exec_pkg::st_run;
            end
            cpu_exec_pkg::st_brkx: begin
                state_d = cpu_exec_pkg::st_halt;
            end
            cpu_exec_pkg::st_call2: begin
                state_d = cpu_exec_pkg::st_call3;
            end
            cpu_exec_pkg::st_call3: begin
                state_d = cpu_exec_pkg::st_run;
            end
            cpu_exec_pkg::st_halt: begin
                // Only a debug command leaves halt; the skip is owed from breakx
                if (resume_evt) begin
                    state_d = resume_skip_q ? cpu_exec_pkg::st_skip
                                            : cpu_exec_pkg::st_run;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q <= cpu_exec_pkg::st_run;
            pc_q    <= `RST_PC;
        end else begin
            state_q <= state_d;
            pc_q    <= pc_d;
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            resume_skip_q <= 1'b0;
        end else if (is_breakx) begin
            resume_skip_q <= 1'b1;
        end else if (is_break) begin
            resume_skip_q <= 1'b0;
        end
    end

    // ==========================================================
    // APB slave: zero wait states, read data captured in setup phase
    wire setup    = psel_i & ~penable_i;
    wire apb_wr   = psel_i & penable_i & pwrite_i;
    wire hit_stat = (paddr_i == `REG_STATUS);
    wire hit_acc  = (paddr_i == `REG_ACC);
    wire hit_pc   = (paddr_i == `REG_PC);
    wire hit_top  = (paddr_i == `REG_STACK_TOP);
    wire hit_fadr = (paddr_i == `REG_FILE_ADDR);
    wire hit_fdat = (paddr_i == `REG_FILE_DATA);
    wire hit_any  = hit_stat | hit_acc | hit_pc | hit_top | hit_fadr | hit_fdat;
    wire wr_stat  = apb_wr & hit_stat;
    wire wr_fdat  = apb_wr & hit_fdat;

    wire [31:0] status_word = {23'h00_0000, halted_o, 2'b00, page_q,
                               zero_q, nibble_q, carry_q};
    wire [31:0] rd_mux = hit_stat ? status_word
                       : hit_acc  ? {24'h00_0000, acc_q}
                       : hit_pc   ? {16'h0000, pc_q}
                       : hit_top  ? {16'h0000, stack_top}
                       : hit_fadr ? {23'h00_0000, file_addr_q}
                       : hit_fdat ? {24'h00_0000, file_q[file_addr_q]}
                       : 32'h0000_0000;

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            prdata_q <= 32'h0000_0000;
            slverr_q <= 1'b0;
        end else if (setup) begin
            prdata_q <= pwrite_i ? 32'h0000_0000 : rd_mux;
            slverr_q <= ~hit_any;
        end
    end

    assign prdata_o  = prdata_q;
    assign pslverr_o = slverr_q & psel_i & penable_i;
    assign pready_o  = 1'b1;

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            acc_q       <= `RST_ACC;
            file_addr_q <= 9'h000;
        end else begin
            if (apb_wr & hit_acc) begin
                acc_q <= pwdata_i[7:0];
            end
            if (apb_wr & hit_fadr) begin
                file_addr_q <= pwdata_i[8:0];
            end
        end
    end

    // ==========================================================
    // Flags: the executing instruction wins over a software write
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            {zero_q, nibble_q, carry_q} <= `RST_FLAGS;
            page_q                      <= `RST_PAGE;
        end else begin
            if (wr_stat) begin
                page_q <= pwdata_i[`FLD_PAGE_HI:`FLD_PAGE_LO];
            end
            if (flags_wr) begin
                carry_q  <= cmp_bus.carry;
                nibble_q <= cmp_bus.nibble_carry;
                zero_q   <= cmp_bus.zero;
            end else if (is_clr) begin
                zero_q <= 1'b1;
            end else if (wr_stat) begin
                carry_q  <= pwdata_i[`FLD_CARRY];
                nibble_q <= pwdata_i[`FLD_NIBBLE];
                zero_q   <= pwdata_i[`FLD_ZERO];
            end
        end
    end

    // ==========================================================
    // Data file: core writes take the port over software writes
    always_ff @(posedge ref_clk_i) begin
        if (is_clr) begin
            file_q[f_addr] <= 8'h00;
        end else if (is_clrb) begin
            file_q[f_addr][bit_sel] <= 1'b0;
        end else if (wr_fdat) begin
            file_q[file_addr_q] <= pwdata_i[7:0];
        end
    end

    assign pc_o     = pc_q;
    assign halted_o = (state_q == cpu_exec_pkg::st_halt);

    // ==========================================================
    // Assertions
    property p_break_halts;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        is_break |=> halted_o && pc_q == $past(pc_q) + 16'h0001;
    endproperty
    a_break_halts: assert property (p_break_halts)
        else $error("break did not halt after one cycle");

    property p_halt_holds;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        halted_o && !resume_evt |=> halted_o && $stable(pc_q);
    endproperty
    a_halt_holds: assert property (p_halt_holds)
        else $error("halt left without a debug command");

    property p_breakx_two;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        is_breakx |=> !halted_o ##1 halted_o && resume_skip_q;
    endproperty
    a_breakx_two: assert property (p_breakx_two)
        else $error("breakx did not halt after two cycles");

    property p_resume_skip;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        halted_o && resume_evt && resume_skip_q |=> state_q == cpu_exec_pkg::st_skip;
    endproperty
    a_resume_skip: assert property (p_resume_skip)
        else $error("breakx resume did not skip");

    property p_call_push;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        is_call |=> stack_top == $past(pc_q) + 16'h0001
                    && pc_q == {$past(page_q), $past(instr_i[12:0])};
    endproperty
    a_call_push: assert property (p_call_push)
        else $error("call pushed or jumped wrongly");

    property p_call_three;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        is_call |=> !running [*2] ##1 running;
    endproperty
    a_call_three: assert property (p_call_three)
        else $error("call did not take three cycles");

    property p_clr;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        is_clr |=> zero_q && file_q[$past(f_addr)] == 8'h00;
    endproperty
    a_clr: assert property (p_clr)
        else $error("clear failed");

    property p_clrb;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        is_clrb && !wr_stat |=> file_q[$past(f_addr)]
            == ($past(file_operand) & ~(8'h01 << $past(bit_sel)))
            && $stable({carry_q, nibble_q, zero_q});
    endproperty
    a_clrb: assert property (p_clrb)
        else $error("bit clear wrong");

    property p_cmp_flags;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        flags_wr |=> carry_q == ($past(cmp_bus.operand) >= $past(acc_q))
            && zero_q == ($past(cmp_bus.operand) == $past(acc_q))
            && nibble_q == ($past(cmp_bus.operand[3:0]) >= $past(acc_q[3:0]))
            && $stable(acc_q);
    endproperty
    a_cmp_flags: assert property (p_cmp_flags)
        else $error("compare flags wrong");

    property p_skip_flow;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        is_skip_op && !wr_stat |=> $stable({carry_q, nibble_q, zero_q})
            && (running != $past(skip_taken));
    endproperty
    a_skip_flow: assert property (p_skip_flow)
        else $error("compare-skip flow or flags wrong");

    property p_annul;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        state_q == cpu_exec_pkg::st_skip && !wr_stat
            |=> $stable({carry_q, nibble_q, zero_q}) && $stable(stack_top) && running;
    endproperty
    a_annul: assert property (p_annul)
        else $error("annulled instruction had effect");

    c_break: cover property (@(posedge ref_clk_i) disable iff (!nrst_i)
        is_break ##1 halted_o [*3] ##1 !halted_o);
    c_call: cover property (@(posedge ref_clk_i) disable iff (!nrst_i) is_call);
    c_skip: cover property (@(posedge ref_clk_i) disable iff (!nrst_i)
        skip_taken ##1 state_q == cpu_exec_pkg::st_skip);
endmodule

/* prog_mem_model.sv */
// Program memory seen by the execution core: one 16-bit word per address.
// Assumes the core reads the word at its program counter in the same cycle.
`timescale 1ns/1ps
module prog_mem_model (
    input  wire logic [15:0] addr_i,
    output logic      [15:0] data_o
);
    // Unwritten words read as zero, which the core treats as a no-operation
    logic [15:0] mem [65536];

    initial begin
        foreach (mem[i]) begin
            mem[i] = 16'h0000;
        end
    end

    // Answers at once; the core has no wait input, so a slow answer cannot be modelled
    assign data_o = mem[addr_i];
endmodule

/* cpu_break_call_compare_ops_tb_top.sv */
// Self-checking bench for the break, call, clear and compare execution core.
// Assumes a zero-wait APB slave and a combinational program memory model.
`timescale 1ns/1ps
`include "cpu_exec_params.svh"
module cpu_break_call_compare_ops_tb_top;
    logic        ref_clk_i;
    logic        nrst_i;
    logic        debug_resume_i;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [15:0] pc;
    logic [15:0] instr;
    logic        halted;
    logic [31:0] rd;
    logic        err;
    int          num_errors = 0;
    int          n_checks = 0;

    cpu_break_call_compare_ops i_cpu_break_call_compare_ops (
        .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .pc_o(pc), .instr_i(instr),
        .debug_resume_i(debug_resume_i), .halted_o(halted), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr));

    prog_mem_model i_prog_mem_model (.addr_i(pc), .data_o(instr));

    initial begin
        ref_clk_i = 1'b0;
        forever #10 ref_clk_i = ~ref_clk_i;
    end

    // ==========================================================
    // Shared tasks
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk_i);
        penable <= 1'b1;
        // Request stands until pready is seen high at a rising edge
        do @(posedge ref_clk_i); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_halt(input logic want);
        for (int i = 0; i < 200 && halted !== want; i++) @(negedge ref_clk_i);
        chk("halted_o", 32'(want), 32'(halted));
    endtask

    // Reset exits break mode; the word at address 0 halts the core again
    task automatic boot();
        @(posedge ref_clk_i);
        nrst_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        wait_halt(1'b1);
    endtask

    task automatic resume();
        @(posedge ref_clk_i);
        debug_resume_i <= 1'b1;
        wait_halt(1'b0);
        @(posedge ref_clk_i);
        debug_resume_i <= 1'b0;
        wait_halt(1'b1);
    endtask

    task automatic load(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
        i_prog_mem_model.mem[1] = a;
        i_prog_mem_model.mem[2] = b;
        i_prog_mem_model.mem[3] = c;
    endtask

    task automatic file_wr(input logic [8:0] a, input logic [7:0] d);
        apb(1'b1, `REG_FILE_ADDR, 32'(a));
        apb(1'b1, `REG_FILE_DATA, 32'(d));
    endtask

    task automatic file_chk(input logic [8:0] a, input logic [7:0] d);
        apb(1'b1, `REG_FILE_ADDR, 32'(a));
        apb(1'b0, `REG_FILE_DATA, 32'h0000_0000);
        chk("file data", 32'(d), rd);
    endtask

    task automatic reg_chk(input string what, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(what, e, rd);
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_break();
        boot();
        repeat (30) @(negedge ref_clk_i);
        chk("pc_o while halted", 32'h0000_0001, 32'(pc));
        chk("pready_o", 32'h0000_0001, 32'(pready));
        reg_chk("status after break", `REG_STATUS, 32'h0000_0100);
        apb(1'b0, 8'h40, 32'h0000_0000);
        chk("pslverr unmapped", 32'h0000_0001, 32'(err));
    endtask

    task automatic t_cmp();
        logic [7:0] lit [4] = '{8'h0F, 8'h10, 8'h10, 8'h00};
        logic [7:0] w [4] = '{8'h06, 8'h10, 8'h20, 8'h01};
        logic [2:0] e [4] = '{3'b011, 3'b111, 3'b010, 3'b000};
        for (int i = 0; i < 4; i++) begin
            load({`OPC_CMPL, lit[i]}, `OPC_BREAK, `OPC_BREAK);
            boot();
            apb(1'b1, `REG_ACC, 32'(w[i]));
            resume();
            apb(1'b0, `REG_STATUS, 32'h0000_0000);
            chk("literal compare flags", 32'(e[i]), 32'(rd[2:0]));
            reg_chk("acc after compare", `REG_ACC, 32'(w[i]));
        end
        // Borrow out of the low nibble only: carry set, nibble carry clear
        load({`OPC_CMP, 9'h099}, `OPC_BREAK, `OPC_BREAK);
        boot();
        file_wr(9'h099, 8'h35);
        apb(1'b1, `REG_ACC, 32'h0000_0006);
        resume();
        apb(1'b0, `REG_STATUS, 32'h0000_0000);
        chk("register compare flags", 32'h0000_0001, 32'(rd[2:0]));
        file_chk(9'h099, 8'h35);
        reg_chk("acc after compare", `REG_ACC, 32'h0000_0006);
    endtask

    task automatic t_clr();
        load({`OPC_CLR, 9'h099}, {`OPC_CLRB, 3'd7, 9'h0A0}, `OPC_BREAK);
        boot();
        file_wr(9'h099, 8'h5A);
        file_wr(9'h0A0, 8'hFF);
        resume();
        file_chk(9'h099, 8'h00);
        file_chk(9'h0A0, 8'h7F);
        reg_chk("status after clear", `REG_STATUS, 32'h0000_0104);
    endtask

    task automatic t_skip();
        logic [15:0] op [4] = '{{`OPC_CSE, 9'h099}, {`OPC_CSNE, 9'h099},
                                {`OPC_CSEL, 8'h3C}, {`OPC_CSNEL, 8'h3C}};
        logic skip;
        for (int i = 0; i < 4; i++) begin
            for (int eq = 0; eq < 2; eq++) begin
                load(op[i], {`OPC_CLR, 9'h0A0}, `OPC_BREAK);
                boot();
                file_wr(9'h099, 8'h3C);
                file_wr(9'h0A0, 8'h77);
                apb(1'b1, `REG_ACC, eq ? 32'h0000_003C : 32'h0000_003D);
                apb(1'b1, `REG_STATUS, 32'h0000_0003);
                resume();
                skip = ((i % 2) == 0) == (eq == 1);
                file_chk(9'h0A0, skip ? 8'h77 : 8'h00);
                reg_chk("skip flags", `REG_STATUS, skip ? 32'h0000_0103 : 32'h0000_0107);
                file_chk(9'h099, 8'h3C);
            end
        end
    endtask

    task automatic t_call();
        load({3'b110, 13'h0123}, `OPC_BREAK, `OPC_BREAK);
        i_prog_mem_model.mem[16'hA123] = `OPC_BREAK;
        boot();
        apb(1'b1, `REG_STATUS, 32'h0000_0028);
        resume();
        chk("pc after call", 32'h0000_A124, 32'(pc));
        reg_chk("stack top", `REG_STACK_TOP, 32'h0000_0002);
    endtask

    task automatic t_breakx();
        load(`OPC_BREAKX, {`OPC_CLR, 9'h0A0}, `OPC_BREAK);
        boot();
        file_wr(9'h0A0, 8'h55);
        resume();
        chk("pc after breakx", 32'h0000_0002, 32'(pc));
        resume();
        chk("pc after skip", 32'h0000_0004, 32'(pc));
        file_chk(9'h0A0, 8'h55);
    endtask

    // ==========================================================
    // Sequence, verdict and watchdog
    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        nrst_i = 1'b0;
        debug_resume_i = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        repeat (20) @(posedge ref_clk_i);
        // Written after time zero so the model's own clearing cannot overwrite it
        i_prog_mem_model.mem[0] = `OPC_BREAK;
        t_break();
        t_cmp();
        t_clr();
        t_skip();
        t_call();
        t_breakx();
        end_of_test();
    end

    // About twenty boots of at most some fifty cycles each; this leaves ample margin
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        num_errors++;
        end_of_test();
    end
endmodule
